// [logic/pms_pkg.sv]
// shared constants, states and carriers of the pressure mat safety monitor
package pms_pkg;

    // register byte offsets
    localparam logic [3:0] PMS_CTRL_OFS = 4'h0;
    localparam logic [3:0] PMS_STATUS_OFS = 4'h4;
    localparam logic [3:0] PMS_IRQ_STAT_OFS = 4'h8;
    localparam logic [3:0] PMS_IRQ_MASK_OFS = 4'hC;

    // control register fields
    localparam int PMS_CTRL_ENABLE_BIT = 0;
    localparam int PMS_CTRL_AUTO_BIT = 1;
    localparam int PMS_CTRL_START_BIT = 2;
    localparam logic [2:0] PMS_CTRL_RST_VAL = 3'h0;

    // status register fields
    localparam int PMS_ST_READY_BIT = 0;
    localparam int PMS_ST_SAFE_BIT = 1;
    localparam int PMS_ST_DEMAND_BIT = 2;
    localparam int PMS_ST_ACKREQ_BIT = 3;
    localparam int PMS_ST_ERROR_BIT = 4;
    localparam int PMS_ST_DIAG_LSB = 16;

    // interrupt event bits
    localparam int PMS_EV_DEMAND = 0;
    localparam int PMS_EV_ERROR = 1;
    localparam int PMS_EV_ENABLED = 2;
    localparam int PMS_EV_ACKREQ = 3;
    localparam int PMS_EV_W = 4;
    localparam logic [3:0] PMS_IRQ_MASK_RST_VAL = 4'h0;

    // diagnostic words
    localparam logic [15:0] PMS_DIAG_IDLE = 16'h0000;
    localparam logic [15:0] PMS_DIAG_INIT = 16'h8001;
    localparam logic [15:0] PMS_DIAG_WAIT_IN1 = 16'h8802;
    localparam logic [15:0] PMS_DIAG_WAIT_ACK1 = 16'h8402;
    localparam logic [15:0] PMS_DIAG_WAIT_IN2 = 16'h8804;
    localparam logic [15:0] PMS_DIAG_WAIT_ACK2 = 16'h8404;
    localparam logic [15:0] PMS_DIAG_ENABLED = 16'h8000;
    localparam logic [15:0] PMS_DIAG_ERR1 = 16'hC001;
    localparam logic [15:0] PMS_DIAG_ERR2 = 16'hC011;

    // pin level seen before the first clean sample
    localparam logic PMS_MAT_RST_VAL = 1'b0;
    localparam logic PMS_BTN_RST_VAL = 1'b0;

    typedef enum logic [8:0] {
        PMS_S_IDLE = 9'h001,
        PMS_S_INIT = 9'h002,
        PMS_S_WAIT_IN1 = 9'h004,
        PMS_S_WAIT_ACK1 = 9'h008,
        PMS_S_WAIT_IN2 = 9'h010,
        PMS_S_WAIT_ACK2 = 9'h020,
        PMS_S_ENABLED = 9'h040,
        PMS_S_ERR1 = 9'h080,
        PMS_S_ERR2 = 9'h100
    } pms_state_t;

    typedef struct packed {
        logic ready;
        logic safe_enable;
        logic demand;
        logic ack_request;
        logic error;
        logic [15:0] diag;
    } pms_out_t;

endpackage

// [logic/pms_sync.sv]
// three-stage pin synchroniser that accepts a level once two stages agree
module pms_sync #(
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic pin_i, // asynchronous pin level
    output logic level_o // clean level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            s1_reg <= RST_VAL;
            s2_reg <= RST_VAL;
            s3_reg <= RST_VAL;
        end else begin
            s1_reg <= pin_i;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // stage one feeds only stage two, so metastability stays put
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_reg <= RST_VAL;
        end else if (s2_reg == s3_reg) begin
            level_reg <= s3_reg;
        end
    end

    assign level_o = level_reg;
endmodule

// [logic/pms_irq.sv]
// sticky event flags with write-one-to-clear, mask and level interrupt
module pms_irq #(
    parameter int W = 4
) (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic [W-1:0] event_i, // one-cycle event pulses
    input wire logic [W-1:0] clear_i, // one-cycle clear strobes
    input wire logic [W-1:0] mask_i, // enable per flag
    output logic [W-1:0] flags_o, // sticky flags
    output logic irq_o // level interrupt
);
    logic [W-1:0] flags_reg;

    // a new event beats a clear in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= '0;
        end else begin
            flags_reg <= (flags_reg & ~clear_i) | event_i;
        end
    end

    assign flags_o = flags_reg;
    assign irq_o = |(flags_reg & mask_i);
endmodule

// [logic/pms_monitor.sv]
// pressure mat safety monitor: state machine, pin inputs, wishbone regs
//
// Operation
// - mat pressed drops enable in same cycle
// - enable only with mat clear and acknowledge
// - auto option acknowledges once mat clears
// - otherwise reset rising edge re-enables output
// - start option acknowledges first start if mat already clear
// - without it first enable needs reset edge
// - block disable forces idle, highest priority
// - reset held high while waiting is error
// - error: output off, flag set, code shown
// - error cleared only after reset goes low
// - enable low means demand, high means none
// - idle: code 0000, all outputs low
// - waiting for mat: demand high, ready high
// - acknowledge request is inverse of reset
// - stuck reset codes C001 and C011 reported
//
// The register addresses and register access over Wishbone were chosen for this implementation.
module pms_monitor (
    input wire logic clk_i, // 100 MHz system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic mat_clear_in_i, // mat pin, low when pressed
    input wire logic ack_btn_i, // acknowledge (reset) pin
    input wire logic [3:0] wb_adr_i, // wishbone byte address
    input wire logic [31:0] wb_dat_i, // wishbone write data
    input wire logic [3:0] wb_sel_i, // wishbone byte lanes
    input wire logic wb_we_i, // wishbone write
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o, // wishbone acknowledge
    output logic safe_enable_out_o, // high: enabled, no demand
    output logic ready_o, // block active
    output logic demand_flag_o, // waiting for mat to clear
    output logic ack_request_o, // acknowledge wanted
    output logic error_o, // stuck acknowledge input
    output logic [15:0] diag_word_o, // diagnostic code
    output logic irq_o // level interrupt
);

    // ------------------------------------------------------------
    // pin inputs
    // ------------------------------------------------------------
    logic mat_clear;
    logic ack_lvl;

    pms_sync #(
        .RST_VAL(pms_pkg::PMS_MAT_RST_VAL)
    ) u_mat_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(mat_clear_in_i),
        .level_o(mat_clear)
    );

    pms_sync #(
        .RST_VAL(pms_pkg::PMS_BTN_RST_VAL)
    ) u_ack_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i(ack_btn_i),
        .level_o(ack_lvl)
    );

    // previous acknowledge sample for edge detection
    logic ack_prev_reg;
    logic ack_rise;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_prev_reg <= pms_pkg::PMS_BTN_RST_VAL;
        end else begin
            ack_prev_reg <= ack_lvl;
        end
    end

    assign ack_rise = ack_lvl & ~ack_prev_reg;

    // ------------------------------------------------------------
    // control register
    // ------------------------------------------------------------
    logic [2:0] ctrl_reg;
    logic blk_enable;
    logic auto_ack;
    logic start_auto_ack;

    assign blk_enable = ctrl_reg[pms_pkg::PMS_CTRL_ENABLE_BIT];
    assign auto_ack = ctrl_reg[pms_pkg::PMS_CTRL_AUTO_BIT];
    assign start_auto_ack = ctrl_reg[pms_pkg::PMS_CTRL_START_BIT];

    // ------------------------------------------------------------
    // state machine
    // ------------------------------------------------------------
    pms_pkg::pms_state_t state_reg;
    pms_pkg::pms_state_t state_next;

    always_comb begin
        state_next = state_reg;
        if (!blk_enable) begin
            state_next = pms_pkg::PMS_S_IDLE;
        end else begin
            case (state_reg)
                pms_pkg::PMS_S_IDLE: begin
                    state_next = pms_pkg::PMS_S_INIT;
                end
                pms_pkg::PMS_S_INIT: begin
                    if (start_auto_ack && mat_clear) begin
                        state_next = pms_pkg::PMS_S_ENABLED;
                    end else begin
                        state_next = pms_pkg::PMS_S_WAIT_IN1;
                    end
                end
                pms_pkg::PMS_S_WAIT_IN1: begin
                    if (ack_lvl) begin
                        state_next = pms_pkg::PMS_S_ERR1;
                    end else if (mat_clear) begin
                        state_next = pms_pkg::PMS_S_WAIT_ACK1;
                    end
                end
                pms_pkg::PMS_S_WAIT_ACK1: begin
                    if (!mat_clear) begin
                        state_next = pms_pkg::PMS_S_WAIT_IN1;
                    end else if (ack_rise) begin
                        state_next = pms_pkg::PMS_S_ENABLED;
                    end
                end
                pms_pkg::PMS_S_ENABLED: begin
                    if (!mat_clear) begin
                        state_next = pms_pkg::PMS_S_WAIT_IN2;
                    end
                end
                pms_pkg::PMS_S_WAIT_IN2: begin
                    if (ack_lvl) begin
                        state_next = pms_pkg::PMS_S_ERR2;
                    end else if (mat_clear) begin
                        state_next = pms_pkg::PMS_S_WAIT_ACK2;
                    end
                end
                pms_pkg::PMS_S_WAIT_ACK2: begin
                    if (!mat_clear) begin
                        state_next = pms_pkg::PMS_S_WAIT_IN2;
                    end else if (auto_ack) begin
                        state_next = pms_pkg::PMS_S_ENABLED;
                    end else if (ack_rise) begin
                        state_next = pms_pkg::PMS_S_ENABLED;
                    end
                end
                pms_pkg::PMS_S_ERR1: begin
                    if (!ack_lvl) begin
                        state_next = pms_pkg::PMS_S_WAIT_IN1;
                    end
                end
                pms_pkg::PMS_S_ERR2: begin
                    if (!ack_lvl) begin
                        state_next = pms_pkg::PMS_S_WAIT_IN2;
                    end
                end
                default: begin
                    state_next = pms_pkg::PMS_S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= pms_pkg::PMS_S_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // output decode
    // ------------------------------------------------------------
    // per-state output word; enable and request are gated below
    function automatic pms_pkg::pms_out_t state_outputs(
        input pms_pkg::pms_state_t st
    );
        pms_pkg::pms_out_t o;
        o = '0;
        case (st)
            pms_pkg::PMS_S_IDLE: begin
                o.diag = pms_pkg::PMS_DIAG_IDLE;
            end
            pms_pkg::PMS_S_INIT: begin
                o.ready = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_INIT;
            end
            pms_pkg::PMS_S_WAIT_IN1: begin
                o.ready = 1'b1;
                o.demand = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_WAIT_IN1;
            end
            pms_pkg::PMS_S_WAIT_ACK1: begin
                o.ready = 1'b1;
                o.ack_request = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_WAIT_ACK1;
            end
            pms_pkg::PMS_S_WAIT_IN2: begin
                o.ready = 1'b1;
                o.demand = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_WAIT_IN2;
            end
            pms_pkg::PMS_S_WAIT_ACK2: begin
                o.ready = 1'b1;
                o.ack_request = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_WAIT_ACK2;
            end
            pms_pkg::PMS_S_ENABLED: begin
                o.ready = 1'b1;
                o.safe_enable = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_ENABLED;
            end
            pms_pkg::PMS_S_ERR1: begin
                o.ready = 1'b1;
                o.error = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_ERR1;
            end
            pms_pkg::PMS_S_ERR2: begin
                o.ready = 1'b1;
                o.error = 1'b1;
                o.diag = pms_pkg::PMS_DIAG_ERR2;
            end
            default: begin
                o = '0;
            end
        endcase
        return o;
    endfunction

    pms_pkg::pms_out_t outs;

    assign outs = state_outputs(state_reg);

    // gating with the live mat level removes the state latency, so the
    // enable falls in the very cycle the mat is seen pressed
    assign safe_enable_out_o = outs.safe_enable & mat_clear & blk_enable;
    assign ack_request_o = outs.ack_request & ~ack_lvl;
    assign ready_o = outs.ready;
    assign demand_flag_o = outs.demand;
    assign error_o = outs.error;
    assign diag_word_o = outs.diag;

    // ------------------------------------------------------------
    // events for the interrupt block
    // ------------------------------------------------------------
    logic safe_prev_reg;
    logic err_prev_reg;
    logic req_prev_reg;
    logic [pms_pkg::PMS_EV_W-1:0] events;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            safe_prev_reg <= 1'b0;
            err_prev_reg <= 1'b0;
            req_prev_reg <= 1'b0;
        end else begin
            safe_prev_reg <= safe_enable_out_o;
            err_prev_reg <= error_o;
            req_prev_reg <= ack_request_o;
        end
    end

    always_comb begin
        events = '0;
        events[pms_pkg::PMS_EV_DEMAND] = safe_prev_reg & ~safe_enable_out_o;
        events[pms_pkg::PMS_EV_ERROR] = error_o & ~err_prev_reg;
        events[pms_pkg::PMS_EV_ENABLED] = safe_enable_out_o & ~safe_prev_reg;
        events[pms_pkg::PMS_EV_ACKREQ] = ack_request_o & ~req_prev_reg;
    end

    // ------------------------------------------------------------
    // wishbone slave, one wait state, registered read data
    // ------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [pms_pkg::PMS_EV_W-1:0] mask_reg;
    logic [pms_pkg::PMS_EV_W-1:0] irq_flags;
    logic [pms_pkg::PMS_EV_W-1:0] irq_clear;
    logic bus_req;
    logic wr_done;

    assign bus_req = wb_cyc_i & wb_stb_i;
    // writes land on the edge where the master sees ack
    assign wr_done = bus_req & ack_reg & wb_we_i & wb_sel_i[0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_reg <= 32'h0;
        end else if (bus_req && !ack_reg) begin
            rdat_reg <= 32'h0;
            case (wb_adr_i)
                pms_pkg::PMS_CTRL_OFS: begin
                    rdat_reg[2:0] <= ctrl_reg;
                end
                pms_pkg::PMS_STATUS_OFS: begin
                    rdat_reg[pms_pkg::PMS_ST_READY_BIT] <= ready_o;
                    rdat_reg[pms_pkg::PMS_ST_SAFE_BIT] <= safe_enable_out_o;
                    rdat_reg[pms_pkg::PMS_ST_DEMAND_BIT] <= demand_flag_o;
                    rdat_reg[pms_pkg::PMS_ST_ACKREQ_BIT] <= ack_request_o;
                    rdat_reg[pms_pkg::PMS_ST_ERROR_BIT] <= error_o;
                    rdat_reg[pms_pkg::PMS_ST_DIAG_LSB +: 16] <= diag_word_o;
                end
                pms_pkg::PMS_IRQ_STAT_OFS: begin
                    rdat_reg[pms_pkg::PMS_EV_W-1:0] <= irq_flags;
                end
                pms_pkg::PMS_IRQ_MASK_OFS: begin
                    rdat_reg[pms_pkg::PMS_EV_W-1:0] <= mask_reg;
                end
                default: begin
                    rdat_reg <= 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= pms_pkg::PMS_CTRL_RST_VAL;
        end else if (wr_done && wb_adr_i == pms_pkg::PMS_CTRL_OFS) begin
            ctrl_reg <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_reg <= pms_pkg::PMS_IRQ_MASK_RST_VAL;
        end else if (wr_done && wb_adr_i == pms_pkg::PMS_IRQ_MASK_OFS) begin
            mask_reg <= wb_dat_i[pms_pkg::PMS_EV_W-1:0];
        end
    end

    always_comb begin
        irq_clear = '0;
        if (wr_done && wb_adr_i == pms_pkg::PMS_IRQ_STAT_OFS) begin
            irq_clear = wb_dat_i[pms_pkg::PMS_EV_W-1:0];
        end
    end

    pms_irq #(
        .W(pms_pkg::PMS_EV_W)
    ) u_irq (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .event_i(events),
        .clear_i(irq_clear),
        .mask_i(mask_reg),
        .flags_o(irq_flags),
        .irq_o(irq_o)
    );

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;

endmodule

// [tb/pms_monitor_assertions.sv]
// concurrent checks on the pressure mat monitor ports
module pms_monitor_assertions (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic mat_clear_in_i, // mat pin
    input wire logic ack_btn_i, // acknowledge pin
    input wire logic [3:0] wb_adr_i, // bus address
    input wire logic [31:0] wb_dat_i, // bus write data
    input wire logic [3:0] wb_sel_i, // bus lanes
    input wire logic wb_we_i, // bus write
    input wire logic wb_ack_o, // bus acknowledge
    input wire logic safe_enable_out_o, // safety output
    input wire logic ready_o, // block active
    input wire logic demand_flag_o, // waiting for mat
    input wire logic ack_request_o, // acknowledge wanted
    input wire logic error_o, // stuck acknowledge
    input wire logic [15:0] diag_word_o // diagnostic code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    sequence ctrl_off_s;
        wb_ack_o && wb_we_i && wb_adr_i == 4'h0 && wb_sel_i[0]
            && !wb_dat_i[0];
    endsequence
    sequence mat_down_s;
        !mat_clear_in_i [*3];
    endsequence
    // the wait state is left on the fifth sample, so six could never match
    sequence btn_stuck_s;
        (demand_flag_o && ack_btn_i) [*5];
    endsequence

    idle_outputs_a: assert property (
        diag_word_o == 16'h0000 |-> !ready_o && !safe_enable_out_o
            && !demand_flag_o && !ack_request_o && !error_o)
        else $error("idle with an output high");
    // the pin passes the model-free synchroniser, hence the short window
    mat_drop_a: assert property (
        mat_down_s |-> ##[0:4] !safe_enable_out_o)
        else $error("output stayed on with mat pressed");
    error_outputs_a: assert property (
        error_o |-> ready_o && !safe_enable_out_o && !demand_flag_o
            && !ack_request_o
            && (diag_word_o == 16'hC001 || diag_word_o == 16'hC011))
        else $error("error state outputs wrong");
    demand_outputs_a: assert property (
        demand_flag_o |-> ready_o && !safe_enable_out_o && !error_o
            && (diag_word_o == 16'h8802 || diag_word_o == 16'h8804))
        else $error("demand state outputs wrong");
    safe_state_a: assert property (
        safe_enable_out_o |-> diag_word_o == 16'h8000 && ready_o
            && !ack_request_o && !demand_flag_o)
        else $error("output on outside enabled state");
    ack_req_state_a: assert property (
        ack_request_o |-> !safe_enable_out_o
            && (diag_word_o == 16'h8402 || diag_word_o == 16'h8404))
        else $error("acknowledge request outside wait");
    disable_idle_a: assert property (
        ctrl_off_s |-> ##[1:2] diag_word_o == 16'h0000)
        else $error("disable did not reach idle");
    stuck_btn_a: assert property (
        btn_stuck_s |-> ##[0:2] (error_o || !ready_o))
        else $error("held acknowledge not flagged");
    err_hold_a: assert property (
        (error_o && ack_btn_i) [*6] |=> error_o || !ready_o)
        else $error("error left with acknowledge high");
endmodule

bind pms_monitor pms_monitor_assertions chk (
    .clk_i(clk_i), .rst_i(rst_i), .mat_clear_in_i(mat_clear_in_i),
    .ack_btn_i(ack_btn_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
    .safe_enable_out_o(safe_enable_out_o), .ready_o(ready_o),
    .demand_flag_o(demand_flag_o), .ack_request_o(ack_request_o),
    .error_o(error_o), .diag_word_o(diag_word_o)
);

// [tb/pms_mat_model.sv]
// mat or bumper contact: opens its circuit while pressed
module pms_mat_model (
    input wire logic clk_i, // system clock
    input wire logic press_i, // mat pressed by the bench
    input wire logic slow_i, // contact settles three cycles late
    output logic mat_clear_o = 1'b0 // contact level, low when pressed
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hist = 3'h0;

    // actuation always shows as a low level on the line
    always @(posedge clk_i) begin
        hist <= {hist[1:0], ~press_i};
        mat_clear_o <= slow_i ? hist[2] : ~press_i;
    end
endmodule

// [tb/testbench.sv]
// self-checking bench of the pressure mat safety monitor
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic press = 1'b0;
    logic slow = 1'b0;
    logic ack_btn_i = 1'b0;
    logic [3:0] wb_adr_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic [31:0] wb_dat_o, rd, opt;
    logic wb_ack_o, mat_clear, safe_o, ready_o, demand_o, ackreq_o;
    logic err_o, irq_o;
    logic [15:0] diag_o;
    int failures = 0;
    int tests_run = 0;
    int seed = 32'h82c633da;

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    pms_mat_model mat (.clk_i(clk_i), .press_i(press), .slow_i(slow),
        .mat_clear_o(mat_clear));
    pms_monitor dut (.clk_i(clk_i), .rst_i(rst_i),
        .mat_clear_in_i(mat_clear), .ack_btn_i(ack_btn_i),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
        .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .safe_enable_out_o(safe_o), .ready_o(ready_o),
        .demand_flag_o(demand_o), .ack_request_o(ackreq_o),
        .error_o(err_o), .diag_word_o(diag_o), .irq_o(irq_o));

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            failures++;
            $display("[ERR] %0t wait ran out", $time);
            finish_test();
        end
    endtask

    // expected pins follow from the diagnostic code and the acknowledge pin level
    function automatic pms_pkg::pms_out_t exp_out(input logic [15:0] dg,
            input logic btn);
        pms_pkg::pms_out_t o;
        o.diag = dg;
        o.ready = dg != 16'h0000;
        o.safe_enable = dg == 16'h8000;
        o.demand = dg[15:8] == 8'h88;
        o.ack_request = dg[15:8] == 8'h84 && !btn;
        o.error = dg[15:14] == 2'b11;
        return o;
    endfunction

    task automatic wb(input logic [3:0] a, input logic we,
            input logic [31:0] d);
        int k;
        @(posedge clk_i);
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_dat_i <= d;
        wb_sel_i <= 4'hF;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        give_up(k, 20);
    endtask

    task automatic drive(input logic p, input logic b);
        @(posedge clk_i);
        press <= p;
        ack_btn_i <= b;
    endtask

    task automatic expect_state(input logic [15:0] dg);
        int k;
        k = 0;
        while (diag_o !== dg && k < 60) begin
            @(posedge clk_i);
            k++;
        end
        give_up(k, 60);
        repeat (2) @(posedge clk_i);
        check(32'({ready_o, safe_o, demand_o, ackreq_o, err_o, diag_o}),
            32'(exp_out(dg, ack_btn_i)));
    endtask

    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(4'h0, 1'b0, 32'h0);
        check(rd, 32'h0);
        wb(4'h8, 1'b0, 32'h0);
        check(rd, 32'h0);
        wb(4'h1, 1'b0, 32'h0);
        check(rd, 32'h0);
        expect_state(16'h0000);
        $display("reset test done");
        wb(4'h0, 1'b1, 32'h1);
        expect_state(16'h8402);
        drive(1'b0, 1'b1);
        expect_state(16'h8000);
        wb(4'h4, 1'b0, 32'h0);
        check(rd, 32'h80000003);
        drive(1'b1, 1'b0);
        expect_state(16'h8804);
        wb(4'hC, 1'b1, 32'h1);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h1);
        wb(4'h8, 1'b1, 32'hF);
        repeat (2) @(posedge clk_i);
        check(32'(irq_o), 32'h0);
        wb(4'hC, 1'b1, 32'h0);
        $display("demand test done");
        drive(1'b1, 1'b1);
        expect_state(16'hC011);
        drive(1'b0, 1'b1);
        repeat (10) @(posedge clk_i);
        expect_state(16'hC011);
        drive(1'b0, 1'b0);
        expect_state(16'h8404);
        drive(1'b0, 1'b1);
        expect_state(16'h8000);
        wb(4'h0, 1'b1, 32'h0);
        expect_state(16'h0000);
        wb(4'h0, 1'b1, 32'h1);
        drive(1'b1, 1'b1);
        expect_state(16'hC001);
        drive(1'b1, 1'b0);
        expect_state(16'h8802);
        wb(4'h0, 1'b1, 32'h0);
        $display("stuck acknowledge test done");
        drive(1'b0, 1'b0);
        // cleared mat must pass the synchroniser before the start check
        repeat (8) @(posedge clk_i);
        wb(4'h0, 1'b1, 32'h5);
        expect_state(16'h8000);
        drive(1'b1, 1'b0);
        expect_state(16'h8804);
        drive(1'b0, 1'b0);
        expect_state(16'h8404);
        $display("start option test done");
        for (int i = 0; i < 6; i++) begin
            opt = $random(seed);
            slow <= opt[2];
            wb(4'h0, 1'b1, {29'h0, opt[0], opt[1], 1'b1});
            drive(1'b1, 1'b0);
            expect_state(16'h8804);
            repeat (opt[6:4]) @(posedge clk_i);
            drive(1'b0, 1'b0);
            if (opt[1]) begin
                expect_state(16'h8000);
            end else begin
                expect_state(16'h8404);
                drive(1'b0, 1'b1);
                expect_state(16'h8000);
                drive(1'b0, 1'b0);
            end
        end
        $display("random option test done");
        finish_test();
    end
endmodule
